// *** logic/pot_serial_port.sv ***
`timescale 1ns/100ps
`include "pot_port_defs.svh"

// Behaviour
// - Bus lines recognised only while enable low
// - Match address 0101 plus three strap pins
// - Address LSB one reads, zero writes
// - Acknowledge matching address, then send data
// - First written byte is the command byte
// - Read order: wiper 0, wiper 1, configuration
// - Master ack after configuration restarts cycle
// - Nonvolatile mode: store starts only on STOP
// - Volatile mode: STOP accepted, no store
// - START is SDA fall with SCL high
// - STOP is SDA rise with SCL high
// - Repeated START handled exactly like START
// - Incoming bits sampled on SCL rising edge
// - Outgoing bits driven at SCL falling edge
// - Ninth bit is acknowledge, low means ack
// - Written bytes eight bits MSB first, ack
// - Command top bits select target; 11 ignored
// - Wiper command low six bits are setting
// - Address mismatch: ignore bus until next START
// - No address acknowledge while store is busy
module pot_serial_port
  import pot_port_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       link_scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       port_en_n,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  input  wire logic       nv_store_done,
  output logic            nv_store_start,
  output logic            nv_store_busy,
  output logic [5:0]      wiper0_setting,
  output logic [5:0]      wiper1_setting,
  output logic            cfg_volatile,
  output logic            cfg_zero_cross,
  output logic            cfg_pot_option
);

  // Reset image: bus lines idle high, port disabled, defaults loaded
  localparam core_state_t CORE_RST = '{
    st:       ST_IDLE,
    cnt:      4'h0,
    shift:    8'h00,
    tx:       8'h00,
    rd_sel:   `RD_SEL_WIPER0,
    wiper0:   `WIPER_RESET,
    wiper1:   `WIPER_RESET,
    cfg:      `CFG_RESET,
    dirty:    1'b0,
    busy:     1'b0,
    store_start: 1'b0,
    sda_oe:   1'b0,
    sda_s1:   1'b1,
    sda_s2:   1'b1,
    sda_s3:   1'b1,
    scl_s1:   1'b1,
    scl_s2:   1'b1,
    scl_s3:   1'b1,
    en_s1:    1'b1,
    en_s2:    1'b1,
    tog_s1:   1'b0,
    tog_s2:   1'b0,
    tog_s3:   1'b0,
    strap_s1: 3'h0,
    strap_s2: 3'h0
  };

  core_state_t s_r;
  core_state_t s_nxt;

  logic        cap_bit;
  logic        cap_tog;
  logic        start_det;
  logic        stop_det;
  logic        rise_evt;
  logic        fall_evt;
  logic        addr_hit;
  logic [1:0]  next_sel;

  // Link side bit sampler on the master's clock
  scl_bit_capture u_capture (
    .link_scl (link_scl),
    .rst_n    (rst_n),
    .sda_i    (sda_i),
    .bit_val  (cap_bit),
    .bit_tog  (cap_tog)
  );

  // Byte returned for a read selector
  function automatic logic [7:0] read_byte(
    input logic [1:0] sel,
    input logic [5:0] w0,
    input logic [5:0] w1,
    input logic [2:0] cfg
  );
    logic [7:0] b;
    b = 8'h00;
    // Reserved configuration bits read back as zero
    unique case (sel)
      `RD_SEL_WIPER0: b = {`CMD_WIPER0, w0};
      `RD_SEL_WIPER1: b = {`CMD_WIPER1, w1};
      default:        b = {`CMD_CONFIG, 3'h0, cfg};
    endcase
    return b;
  endfunction : read_byte

  // Bus conditions seen through the synchronised pins
  always_comb begin
    start_det = s_r.scl_s2 && s_r.scl_s3 && s_r.sda_s3 && !s_r.sda_s2;
    stop_det  = s_r.scl_s2 && s_r.scl_s3 && !s_r.sda_s3 && s_r.sda_s2;
    rise_evt  = s_r.tog_s2 ^ s_r.tog_s3;
    fall_evt  = s_r.scl_s3 && !s_r.scl_s2;
  end

  // Straps are synchronised levels; change them only while the bus is idle
  // Address compare against fixed nibble and straps, refused while busy
  always_comb begin
    addr_hit = (s_r.shift[`ADDR_UPPER_MSB:`ADDR_UPPER_LSB] == `ADDR_UPPER_NIBBLE)
            && (s_r.shift[`ADDR_STRAP_MSB:`ADDR_STRAP_LSB] == s_r.strap_s2)
            && !s_r.busy;
  end

  // Round-robin successor of the read selector
  always_comb begin
    if (s_r.rd_sel == `RD_SEL_CONFIG) begin
      next_sel = `RD_SEL_WIPER0;
    end else begin
      next_sel = s_r.rd_sel + 2'h1;
    end
  end

  // Next state of the whole port
  always_comb begin
    s_nxt             = s_r;
    s_nxt.store_start = 1'b0;

    // Data line: two-flop synchroniser, third stage for edge detection
    s_nxt.sda_s1   = sda_i;
    s_nxt.sda_s2   = s_r.sda_s1;
    s_nxt.sda_s3   = s_r.sda_s2;

    // Clock line: same depth as data so START and STOP keep their order
    s_nxt.scl_s1   = link_scl;
    s_nxt.scl_s2   = s_r.scl_s1;
    s_nxt.scl_s3   = s_r.scl_s2;

    // Enable pin: two flops, level only
    s_nxt.en_s1    = port_en_n;
    s_nxt.en_s2    = s_r.en_s1;

    // Link bit toggle: two flops, third stage marks a new bit
    s_nxt.tog_s1   = cap_tog;
    s_nxt.tog_s2   = s_r.tog_s1;
    s_nxt.tog_s3   = s_r.tog_s2;

    // Address straps: two flops, levels only
    s_nxt.strap_s1 = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    s_nxt.strap_s2 = s_r.strap_s1;

    // Store completion clears busy; a new store start below wins
    if (s_r.busy && nv_store_done) begin
      s_nxt.busy = 1'b0;
    end

    // Priority: disable, then START, STOP, clock rise, clock fall
    if (s_r.en_s2) begin
      // Port disabled: release the line and drop any transfer
      s_nxt.st     = ST_IDLE;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.dirty  = 1'b0;
    end else if (start_det) begin
      // Any START, repeated or not, opens an address phase
      s_nxt.st     = ST_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_det) begin
      // End of transfer; nonvolatile writes launch the store here
      s_nxt.st     = ST_IDLE;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
      if (s_r.dirty && !s_r.cfg[`CFG_VOLATILE_BIT]) begin
        s_nxt.store_start = 1'b1;
        s_nxt.busy        = 1'b1;
      end
      // Volatile mode drops the pending flag without a store
      s_nxt.dirty = 1'b0;
    end else if (rise_evt) begin
      // Clock rise: count a data bit or close the acknowledge slot
      if (s_r.st != ST_IDLE && s_r.st != ST_SKIP) begin
        if (s_r.cnt < `BYTE_BITS) begin
          // Data bit: shift in MSB first
          s_nxt.shift = {s_r.shift[6:0], cap_bit};
          s_nxt.cnt   = s_r.cnt + 4'h1;
        end else begin
          // Acknowledge slot just clocked
          s_nxt.cnt = 4'h0;
          unique case (s_r.st)
            ST_ADDR: begin
              // Address byte: continue only on a match while not busy
              if (addr_hit) begin
                if (s_r.shift[`ADDR_RW_BIT]) begin
                  s_nxt.st     = ST_READ;
                  s_nxt.rd_sel = `RD_SEL_WIPER0;
                  s_nxt.tx     = read_byte(`RD_SEL_WIPER0, s_r.wiper0, s_r.wiper1,
                                           s_r.cfg);
                end else begin
                  s_nxt.st = ST_WRITE;
                end
              end else begin
                s_nxt.st = ST_SKIP;
              end
            end
            ST_WRITE: begin
              // Command byte complete and acknowledged: commit it
              unique case (s_r.shift[`CMD_SEL_MSB:`CMD_SEL_LSB])
                `CMD_WIPER0: begin
                  s_nxt.wiper0 = s_r.shift[`WIPER_MSB:0];
                  s_nxt.dirty  = 1'b1;
                end
                `CMD_WIPER1: begin
                  s_nxt.wiper1 = s_r.shift[`WIPER_MSB:0];
                  s_nxt.dirty  = 1'b1;
                end
                `CMD_CONFIG: begin
                  s_nxt.cfg   = s_r.shift[`CFG_MSB:0];
                  s_nxt.dirty = 1'b1;
                end
                default: begin
                  s_nxt.dirty = s_r.dirty;
                end
              endcase
            end
            ST_READ: begin
              // Master ack continues the cycle, nack ends it
              // The captured bit is the master's answer, steady until next rise
              if (!cap_bit) begin
                s_nxt.rd_sel = next_sel;
                s_nxt.tx     = read_byte(next_sel, s_r.wiper0, s_r.wiper1, s_r.cfg);
              end else begin
                s_nxt.st = ST_SKIP;
              end
            end
            default: begin
              s_nxt.st = ST_SKIP;
            end
          endcase
        end
      end
    end else if (fall_evt) begin
      // Line drive changes only while the clock is low
      unique case (s_r.st)
        ST_ADDR:  s_nxt.sda_oe = (s_r.cnt == `BYTE_BITS) && addr_hit;
        ST_WRITE: s_nxt.sda_oe = (s_r.cnt == `BYTE_BITS);
        ST_READ: begin
          if (s_r.cnt < `BYTE_BITS) begin
            // Open drain: a zero bit pulls low, a one bit releases
            s_nxt.sda_oe = !s_r.tx[3'(7 - s_r.cnt)];
          end else begin
            s_nxt.sda_oe = 1'b0;
          end
        end
        default:  s_nxt.sda_oe = 1'b0;
      endcase
    end
  end

  // Core domain state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_o          = 1'b0;
  assign sda_oe         = s_r.sda_oe;

  // Store handshake toward the memory side
  assign nv_store_start = s_r.store_start;
  assign nv_store_busy  = s_r.busy;

  // Register contents toward the analog side
  assign wiper0_setting = s_r.wiper0;
  assign wiper1_setting = s_r.wiper1;
  assign cfg_volatile   = s_r.cfg[`CFG_VOLATILE_BIT];
  assign cfg_zero_cross = s_r.cfg[`CFG_ZERO_CROSS_BIT];
  assign cfg_pot_option = s_r.cfg[`CFG_POT_OPTION_BIT];

endmodule : pot_serial_port

// *** shared/pot_port_defs.svh ***
`ifndef POT_PORT_DEFS_SVH
`define POT_PORT_DEFS_SVH

// Fixed upper nibble of the slave address
`define ADDR_UPPER_NIBBLE   4'h5

// Bit positions inside the slave address byte
`define ADDR_RW_BIT         0
`define ADDR_STRAP_LSB      1
`define ADDR_STRAP_MSB      3
`define ADDR_UPPER_LSB      4
`define ADDR_UPPER_MSB      7

// Command byte selector field and its codes
`define CMD_SEL_MSB         7
`define CMD_SEL_LSB         6
`define CMD_WIPER0          2'h0
`define CMD_WIPER1          2'h1
`define CMD_CONFIG          2'h2
`define WIPER_MSB           5
`define CFG_MSB             2

// Configuration bit positions
`define CFG_VOLATILE_BIT    2
`define CFG_ZERO_CROSS_BIT  1
`define CFG_POT_OPTION_BIT  0

// Reset values
`define CFG_RESET           3'h7
`define WIPER_RESET         6'h3F

// Read round-robin selectors
`define RD_SEL_WIPER0       2'h0
`define RD_SEL_WIPER1       2'h1
`define RD_SEL_CONFIG       2'h2

// Data bits per byte; the next rising edge is the acknowledge slot
`define BYTE_BITS           4'h8

`endif

// *** shared/pot_port_pkg.sv ***
package pot_port_pkg;

  // Protocol phase of the serial port
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_SKIP
  } port_state_t;

  // State held in the link clock domain
  typedef struct packed {
    logic bit_val;
    logic bit_tog;
  } capture_state_t;

  // State held in the core clock domain
  typedef struct packed {
    port_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [1:0]  rd_sel;
    logic [5:0]  wiper0;
    logic [5:0]  wiper1;
    logic [2:0]  cfg;
    logic        dirty;
    logic        busy;
    logic        store_start;
    logic        sda_oe;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        en_s1;
    logic        en_s2;
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_s3;
    logic [2:0]  strap_s1;
    logic [2:0]  strap_s2;
  } core_state_t;

endpackage : pot_port_pkg

// *** logic/scl_bit_capture.sv ***
`timescale 1ns/100ps

module scl_bit_capture
  import pot_port_pkg::*;
(
  input  wire logic link_scl,
  input  wire logic rst_n,
  input  wire logic sda_i,
  output logic      bit_val,
  output logic      bit_tog
);

  capture_state_t cap_r;
  capture_state_t cap_nxt;

  // Take the data line at each clock rise and flag the new bit by a toggle
  always_comb begin
    cap_nxt         = cap_r;
    cap_nxt.bit_val = sda_i;
    cap_nxt.bit_tog = ~cap_r.bit_tog;
  end

  // Link domain registers; bit_val stays put until the next rise
  always_ff @(posedge link_scl or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  assign bit_val = cap_r.bit_val;
  assign bit_tog = cap_r.bit_tog;

endmodule : scl_bit_capture

// *** dv/pot_bus_master.sv ***
`timescale 1ns/100ps

module pot_bus_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // Both lines idle high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // START or repeated START
  task automatic start_c();
    sda_drv = 1'b1;
    #12 scl = 1'b1;
    #12 sda_drv = 1'b0;
    #12 scl = 1'b0;
    #12;
  endtask : start_c

  // STOP, SCL then stays high
  task automatic stop_c();
    sda_drv = 1'b0;
    #12 scl = 1'b1;
    #12 sda_drv = 1'b1;
    #24;
  endtask : stop_c

  // SDA set while SCL low, read back during high phase
  task automatic xfer_bit(input logic b, output logic r);
    sda_drv = b;
    #12 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
    #12;
  endtask : xfer_bit

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer_byte(input logic [7:0] d, input logic ai,
                           output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], q[i]);
    end
    xfer_bit(ai, ao);
  endtask : xfer_byte
endmodule : pot_bus_master

// *** dv/pot_serial_port_chk.sv ***
`timescale 1ns/100ps

module pot_serial_port_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       sda_oe,
  input wire logic       port_en_n,
  input wire logic       nv_store_done,
  input wire logic       nv_store_start,
  input wire logic       nv_store_busy,
  input wire logic [5:0] wiper0_setting,
  input wire logic [5:0] wiper1_setting,
  input wire logic       cfg_volatile,
  input wire logic       cfg_zero_cross,
  input wire logic       cfg_pot_option
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Port protocol
  chk_off_release: assert property (port_en_n [*5] |=> !sda_oe)
    else $error("SDA held while disabled");
  chk_oe_stands: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("SDA drive too short");
  chk_commit_ack: assert property (
    $changed({wiper0_setting, wiper1_setting, cfg_volatile, cfg_zero_cross, cfg_pot_option})
      |-> $past(sda_oe))
    else $error("Register changed outside ack");
  chk_busy_noack: assert property (nv_store_busy |-> !sda_oe)
    else $error("Ack while store busy");

  // Store handshake
  chk_store_pulse: assert property (nv_store_start |=> !nv_store_start)
    else $error("Store start too long");
  chk_store_busy: assert property (nv_store_start |-> nv_store_busy)
    else $error("Busy missing at start");
  chk_busy_hold: assert property (nv_store_busy && !nv_store_done |=> nv_store_busy)
    else $error("Busy dropped early");
  chk_vol_nostore: assert property (cfg_volatile |-> !nv_store_start)
    else $error("Store in volatile mode");

  cover property ($rose(sda_oe));
  cover property (nv_store_start);
  cover property ($fell(nv_store_busy));
endmodule : pot_serial_port_chk

bind pot_serial_port pot_serial_port_chk u_pot_serial_port_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sda_oe(sda_oe), .port_en_n(port_en_n),
  .nv_store_done(nv_store_done), .nv_store_start(nv_store_start),
  .nv_store_busy(nv_store_busy), .wiper0_setting(wiper0_setting),
  .wiper1_setting(wiper1_setting), .cfg_volatile(cfg_volatile),
  .cfg_zero_cross(cfg_zero_cross), .cfg_pot_option(cfg_pot_option)
);

// *** dv/tb_pot_serial_port.sv ***
`timescale 1ns/100ps
`include "pot_port_defs.svh"

module tb_pot_serial_port import pot_port_pkg::*;;
  typedef struct packed {
    logic [7:0] cmd;
    logic [5:0] w0;
    logic [5:0] w1;
    logic [2:0] cfg;
    logic       st;
  } row_t;

  localparam logic [6:0] ME = {`ADDR_UPPER_NIBBLE, 3'h5};
  logic       core_clk;
  logic       rst_n;
  logic       port_en_n;
  logic [2:0] strap;
  logic       nv_store_done = 1'b0;
  logic       scl;
  logic       sda_drv;
  logic       sda_o;
  logic       sda_oe;
  logic       nv_store_start;
  logic       nv_store_busy;
  logic [5:0] w0;
  logic [5:0] w1;
  logic [2:0] cfg;
  logic [7:0] q;
  logic       ack;
  logic       aack;
  logic [7:0] rd_exp [3];
  int         st_cnt = 0;
  int         error_cnt;
  int         checks;
  wire        sda = sda_drv & (sda_oe ? sda_o : 1'b1);

  // Command, then expected settings and store flag
  row_t rows [7] = '{
    '{8'h2A, 6'h2A, 6'h3F, 3'h7, 1'b0},
    '{8'h55, 6'h2A, 6'h15, 3'h7, 1'b0},
    '{8'hC0, 6'h2A, 6'h15, 3'h7, 1'b0},
    '{8'h83, 6'h2A, 6'h15, 3'h3, 1'b1},
    '{8'h11, 6'h11, 6'h15, 3'h3, 1'b1},
    '{8'h86, 6'h11, 6'h15, 3'h6, 1'b0},
    '{8'h82, 6'h11, 6'h15, 3'h2, 1'b1}
  };

  pot_serial_port u_pot_serial_port (
    .core_clk(core_clk), .rst_n(rst_n), .link_scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .port_en_n(port_en_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .nv_store_done(nv_store_done),
    .nv_store_start(nv_store_start), .nv_store_busy(nv_store_busy),
    .wiper0_setting(w0), .wiper1_setting(w1), .cfg_volatile(cfg[2]),
    .cfg_zero_cross(cfg[1]), .cfg_pot_option(cfg[0])
  );

  pot_bus_master u_pot_bus_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  always #2 core_clk = ~core_clk;

  // Store stand-in: done pulse a while after each start
  always @(posedge core_clk) begin
    nv_store_done <= (st_cnt == 1);
    st_cnt <= nv_store_start ? 300 : (st_cnt != 0 ? st_cnt - 1 : 0);
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Write transaction: address, one command, STOP
  task automatic wr(input logic [6:0] a, input logic [7:0] c);
    u_pot_bus_master.start_c();
    u_pot_bus_master.xfer_byte({a, 1'b0}, 1'b1, q, aack);
    if (aack === 1'b0) begin
      u_pot_bus_master.xfer_byte(c, 1'b1, q, ack);
      check("cmd_ack", {7'h00, ack}, 8'h00);
    end
    u_pot_bus_master.stop_c();
    repeat (8) @(posedge core_clk);
  endtask : wr

  // Bounded wait for the store to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_store_busy !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 2000) begin
        error_cnt++;
        close_out();
      end
    end
  endtask : wait_idle

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    port_en_n = 1'b0;
    strap = 3'h5;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("rst_w0", {2'h0, w0}, {2'h0, `WIPER_RESET});
    check("rst_cfg", {5'h00, cfg}, {5'h00, `CFG_RESET});
    check("rst_w1", {2'h0, w1}, {2'h0, `WIPER_RESET});
    check("rst_oe_busy", {6'h00, sda_oe, nv_store_busy}, 8'h00);
    // Disabled port ignores the bus
    port_en_n <= 1'b1;
    wr(ME, 8'h2A);
    check("off_ack", {7'h00, aack}, 8'h01);
    port_en_n <= 1'b0;
    // Only the strapped address answers
    for (int a = 0; a < 8; a++) begin
      wr({`ADDR_UPPER_NIBBLE, a[2:0]}, 8'hC0);
      check("addr_ack", {7'h00, aack}, {7'h00, a != 5});
    end
    // Other strap levels move the answering address
    strap <= 3'h2;
    wr({`ADDR_UPPER_NIBBLE, 3'h2}, 8'hC0);
    check("strap_ack", {7'h00, aack}, 8'h00);
    strap <= 3'h5;
    foreach (rows[i]) begin
      wr(ME, rows[i].cmd);
      check("w0", {2'h0, w0}, {2'h0, rows[i].w0});
      check("w1", {2'h0, w1}, {2'h0, rows[i].w1});
      check("cfg", {5'h00, cfg}, {5'h00, rows[i].cfg});
      check("store", {7'h00, nv_store_busy}, {7'h00, rows[i].st});
      wait_idle();
    end
    // Round-robin read, last byte refused
    rd_exp = '{{2'h0, rows[6].w0}, {2'h1, rows[6].w1}, {5'h10, rows[6].cfg}};
    u_pot_bus_master.start_c();
    u_pot_bus_master.xfer_byte({ME, 1'b1}, 1'b1, q, ack);
    check("rd_addr_ack", {7'h00, ack}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_pot_bus_master.xfer_byte(8'hFF, i == 3, q, ack);
      check("rd_byte", q, rd_exp[i % 3]);
    end
    u_pot_bus_master.stop_c();
    // Address refused while the store runs
    wr(ME, 8'h07);
    wr(ME, 8'h20);
    check("busy_ack", {7'h00, aack}, 8'h01);
    wait_idle();
    wr(ME, 8'h20);
    check("w0_poll", {2'h0, w0}, 8'h20);
    wait_idle();
    // Enable lost while the port pulls a read bit low
    u_pot_bus_master.start_c();
    u_pot_bus_master.xfer_byte({ME, 1'b1}, 1'b1, q, ack);
    repeat (2) @(posedge core_clk);
    check("drv_oe", {7'h00, sda_oe}, 8'h01);
    port_en_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("off_oe", {7'h00, sda_oe}, 8'h00);
    port_en_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    u_pot_bus_master.stop_c();
    // Partial byte cut by a repeated START
    u_pot_bus_master.start_c();
    u_pot_bus_master.xfer_byte({ME, 1'b0}, 1'b1, q, ack);
    for (int i = 0; i < 4; i++) begin
      u_pot_bus_master.xfer_bit(1'b0, ack);
    end
    u_pot_bus_master.start_c();
    u_pot_bus_master.xfer_byte({ME, 1'b1}, 1'b1, q, ack);
    u_pot_bus_master.xfer_byte(8'hFF, 1'b1, q, ack);
    u_pot_bus_master.stop_c();
    check("partial", q, 8'h20);
    close_out();
  end
endmodule : tb_pot_serial_port
